// ### rtc_defs.vh
// constants for the clock-calendar value registers
// assumes a word-indexed plain register port with 16-bit data
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// =====================================================
// register word offsets
`define RTC_OFS_CTRL 4'h0
`define RTC_OFS_ACFG 4'h1
`define RTC_OFS_TWIN 4'h2
`define RTC_OFS_AWIN 4'h3

// =====================================================
// control and alarm-config fields
`define RTC_UNLOCK_BIT 13
`define RTC_PTR_HI 9
`define RTC_PTR_LO 8
`define RTC_UNLOCK_RST 1'b0
`define RTC_PTR_RST 2'h0
`define RTC_RDATA_RST 16'h0000

// =====================================================
// window pointer codes
`define RTC_PTR_MINSEC 2'h0
`define RTC_PTR_WDHR 2'h1
`define RTC_PTR_MODAY 2'h2
`define RTC_PTR_YEAR 2'h3

// =====================================================
// value field positions
`define RTC_HT_HI 7
`define RTC_HT_LO 4
`define RTC_LO_HI 3
`define RTC_LO_LO 0
`define RTC_MOT_BIT 12
`define RTC_MOO_HI 11
`define RTC_MOO_LO 8
`define RTC_D2_HI 5
`define RTC_D2_LO 4
`define RTC_WD_HI 10
`define RTC_WD_LO 8
`define RTC_MNT_HI 14
`define RTC_MNT_LO 12
`define RTC_MNO_HI 11
`define RTC_MNO_LO 8
`define RTC_ST_HI 6
`define RTC_ST_LO 4

`endif

// ### rtc_value_regs.v
// clock-calendar time and alarm value registers behind a word port
// assumes sec_tick_i is a one-cycle pulse from logic on mclk_i
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"

// Function
// - pointer 11 shows year BCD tens 7-4, ones 3-0, upper byte zero
// - pointer 10 shows month tens bit 12, ones 11-8, read-only
// - day of month tens in bits 5-4, ones 3-0, writable
// - pointer 01 shows weekday 0 to 6 in bits 10-8
// - hour tens in bits 5-4, ones in bits 3-0
// - pointer 00 shows minute tens 14-12, ones 11-8
// - second tens in bits 6-4, ones in bits 3-0
// - year writes only taken while write unlock is one
// - month/day and weekday/hours writes, both windows, need unlock
// - unimplemented value bits read zero and ignore writes
// - alarm pointer 10 holds writable alarm month and day digits
// - alarm pointer 01 holds writable alarm weekday and hour digits
// - time pointer decrements on each window access, holds at 00
// - alarm pointer decrements on each window access, holds at 00
// - alarm pointer 00 holds alarm minutes/seconds, time layout
// - software sets unlock before writing; clearing it locks again
module rtc_value_regs (
    input wire mclk_i,
    input wire resetn_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire sec_tick_i,
    output reg [15:0] rdata_o
);

// =====================================================
// control state
reg time_write_unlock_q;
reg [1:0] time_window_pointer_q;
reg [1:0] alarm_window_pointer_q;

// =====================================================
// time value fields
reg [3:0] year_tens_digit_q;
reg [3:0] year_ones_digit_q;
reg month_tens_digit_q;
reg [3:0] month_ones_digit_q;
reg [1:0] date_tens_digit_q;
reg [3:0] date_ones_digit_q;
reg [2:0] day_of_week_value_q;
reg [1:0] hour_tens_digit_q;
reg [3:0] hour_ones_digit_q;
reg [2:0] minute_tens_digit_q;
reg [3:0] minute_ones_digit_q;
reg [2:0] second_tens_digit_q;
reg [3:0] second_ones_digit_q;

// =====================================================
// alarm value fields
reg alarm_month_tens_q;
reg [3:0] alarm_month_ones_q;
reg [1:0] alarm_date_tens_q;
reg [3:0] alarm_date_ones_q;
reg [2:0] alarm_day_of_week_q;
reg [1:0] alarm_hour_tens_q;
reg [3:0] alarm_hour_ones_q;
reg [2:0] alarm_minute_tens_q;
reg [3:0] alarm_minute_ones_q;
reg [2:0] alarm_second_tens_q;
reg [3:0] alarm_second_ones_q;

reg [15:0] rdata_d;

// =====================================================
// access decode
wire wr_ctrl = wr_i && (addr_i == `RTC_OFS_CTRL);
wire wr_acfg = wr_i && (addr_i == `RTC_OFS_ACFG);
wire wr_twin = wr_i && (addr_i == `RTC_OFS_TWIN);
wire rd_twin = rd_i && (addr_i == `RTC_OFS_TWIN);
wire wr_awin = wr_i && (addr_i == `RTC_OFS_AWIN);
wire rd_awin = rd_i && (addr_i == `RTC_OFS_AWIN);

wire wr_year = wr_twin && time_write_unlock_q &&
    (time_window_pointer_q == `RTC_PTR_YEAR);
wire wr_moday = wr_twin && time_write_unlock_q &&
    (time_window_pointer_q == `RTC_PTR_MODAY);
wire wr_wdhr = wr_twin && time_write_unlock_q &&
    (time_window_pointer_q == `RTC_PTR_WDHR);
wire wr_minsec = wr_twin &&
    (time_window_pointer_q == `RTC_PTR_MINSEC);
wire wr_amoday = wr_awin && time_write_unlock_q &&
    (alarm_window_pointer_q == `RTC_PTR_MODAY);
wire wr_awdhr = wr_awin && time_write_unlock_q &&
    (alarm_window_pointer_q == `RTC_PTR_WDHR);
wire wr_aminsec = wr_awin &&
    (alarm_window_pointer_q == `RTC_PTR_MINSEC);

// =====================================================
// carry chain
// wrap points of each pair
wire sec_wrap = (second_tens_digit_q == 3'h5) &&
    (second_ones_digit_q == 4'h9);
wire min_wrap = (minute_tens_digit_q == 3'h5) &&
    (minute_ones_digit_q == 4'h9);
wire hour_wrap = (hour_tens_digit_q == 2'h2) &&
    (hour_ones_digit_q == 4'h3);
wire day_of_week_value_wrap = (day_of_week_value_q == 3'h6);
wire mon_wrap = month_tens_digit_q &&
    (month_ones_digit_q == 4'h2);
wire year_wrap = (year_tens_digit_q == 4'h9) &&
    (year_ones_digit_q == 4'h9);

// year divisible by four: tens even with ones 0,4,8, or odd with 2,6
wire leap = year_tens_digit_q[0] ?
    (year_ones_digit_q == 4'h2 || year_ones_digit_q == 4'h6) :
    (year_ones_digit_q == 4'h0 || year_ones_digit_q == 4'h4 ||
     year_ones_digit_q == 4'h8);

reg [5:0] last_day;
always @* begin
    last_day = 6'h31;
    if (!month_tens_digit_q) begin
        case (month_ones_digit_q)
            4'h2: begin
                last_day = leap ? 6'h29 : 6'h28;
            end
            4'h4, 4'h6, 4'h9: begin
                last_day = 6'h30;
            end
            default: begin
                last_day = 6'h31;
            end
        endcase
    end else if (month_ones_digit_q == 4'h1) begin
        last_day = 6'h30;
    end
end

// compares BCD packed day against BCD last day
wire date_wrap = ({date_tens_digit_q, date_ones_digit_q} == last_day);

wire c_sec = sec_tick_i;
wire c_min = c_sec && sec_wrap;
wire c_hour = c_min && min_wrap;
wire c_day = c_hour && hour_wrap;
wire c_mon = c_day && date_wrap;
wire c_year = c_mon && mon_wrap;

// =====================================================
// control registers
always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        time_write_unlock_q <= `RTC_UNLOCK_RST;
        time_window_pointer_q <= `RTC_PTR_RST;
        alarm_window_pointer_q <= `RTC_PTR_RST;
    end else begin
        // unlock set and cleared by software
        if (wr_ctrl) begin
            time_write_unlock_q <= wdata_i[`RTC_UNLOCK_BIT];
        end
        if (wr_ctrl) begin
            time_window_pointer_q <= wdata_i[`RTC_PTR_HI:`RTC_PTR_LO];
        end else if ((wr_twin || rd_twin) &&
                     time_window_pointer_q != `RTC_PTR_MINSEC) begin
            time_window_pointer_q <= time_window_pointer_q - 2'h1;
        end
        if (wr_acfg) begin
            alarm_window_pointer_q <= wdata_i[`RTC_PTR_HI:`RTC_PTR_LO];
        end else if ((wr_awin || rd_awin) &&
                     alarm_window_pointer_q != `RTC_PTR_MINSEC) begin
            alarm_window_pointer_q <= alarm_window_pointer_q - 2'h1;
        end
    end
end

// =====================================================
// running time fields
// no reset on value storage, contents unknown until loaded
// a software write in the same cycle as a carry wins over the carry
always @(posedge mclk_i) begin
    if (wr_minsec) begin
        second_tens_digit_q <= wdata_i[`RTC_ST_HI:`RTC_ST_LO];
        second_ones_digit_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end else if (c_sec) begin
        if (second_ones_digit_q == 4'h9) begin
            second_ones_digit_q <= 4'h0;
            second_tens_digit_q <= sec_wrap ? 3'h0 :
                second_tens_digit_q + 3'h1;
        end else begin
            second_ones_digit_q <= second_ones_digit_q + 4'h1;
        end
    end
    if (wr_minsec) begin
        minute_tens_digit_q <= wdata_i[`RTC_MNT_HI:`RTC_MNT_LO];
        minute_ones_digit_q <= wdata_i[`RTC_MNO_HI:`RTC_MNO_LO];
    end else if (c_min) begin
        if (minute_ones_digit_q == 4'h9) begin
            minute_ones_digit_q <= 4'h0;
            minute_tens_digit_q <= min_wrap ? 3'h0 :
                minute_tens_digit_q + 3'h1;
        end else begin
            minute_ones_digit_q <= minute_ones_digit_q + 4'h1;
        end
    end
    if (wr_wdhr) begin
        hour_tens_digit_q <= wdata_i[`RTC_D2_HI:`RTC_D2_LO];
        hour_ones_digit_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end else if (c_hour) begin
        if (hour_wrap) begin
            hour_tens_digit_q <= 2'h0;
            hour_ones_digit_q <= 4'h0;
        end else if (hour_ones_digit_q == 4'h9) begin
            hour_ones_digit_q <= 4'h0;
            hour_tens_digit_q <= hour_tens_digit_q + 2'h1;
        end else begin
            hour_ones_digit_q <= hour_ones_digit_q + 4'h1;
        end
    end
    if (wr_wdhr) begin
        day_of_week_value_q <= wdata_i[`RTC_WD_HI:`RTC_WD_LO];
    end else if (c_day) begin
        day_of_week_value_q <= day_of_week_value_wrap ? 3'h0 :
            day_of_week_value_q + 3'h1;
    end
    // day of month, 01 to last day
    if (wr_moday) begin
        date_tens_digit_q <= wdata_i[`RTC_D2_HI:`RTC_D2_LO];
        date_ones_digit_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end else if (c_day) begin
        if (date_wrap) begin
            date_tens_digit_q <= 2'h0;
            date_ones_digit_q <= 4'h1;
        end else if (date_ones_digit_q == 4'h9) begin
            date_ones_digit_q <= 4'h0;
            date_tens_digit_q <= date_tens_digit_q + 2'h1;
        end else begin
            date_ones_digit_q <= date_ones_digit_q + 4'h1;
        end
    end
    if (c_mon) begin
        if (mon_wrap) begin
            month_tens_digit_q <= 1'b0;
            month_ones_digit_q <= 4'h1;
        end else if (month_ones_digit_q == 4'h9) begin
            month_tens_digit_q <= 1'b1;
            month_ones_digit_q <= 4'h0;
        end else begin
            month_ones_digit_q <= month_ones_digit_q + 4'h1;
        end
    end
    if (wr_year) begin
        year_tens_digit_q <= wdata_i[`RTC_HT_HI:`RTC_HT_LO];
        year_ones_digit_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end else if (c_year) begin
        if (year_wrap) begin
            year_tens_digit_q <= 4'h0;
            year_ones_digit_q <= 4'h0;
        end else if (year_ones_digit_q == 4'h9) begin
            year_ones_digit_q <= 4'h0;
            year_tens_digit_q <= year_tens_digit_q + 4'h1;
        end else begin
            year_ones_digit_q <= year_ones_digit_q + 4'h1;
        end
    end
end

// =====================================================
// alarm fields, software written only
always @(posedge mclk_i) begin
    if (wr_amoday) begin
        alarm_month_tens_q <= wdata_i[`RTC_MOT_BIT];
        alarm_month_ones_q <= wdata_i[`RTC_MOO_HI:`RTC_MOO_LO];
        alarm_date_tens_q <= wdata_i[`RTC_D2_HI:`RTC_D2_LO];
        alarm_date_ones_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end
    if (wr_awdhr) begin
        alarm_day_of_week_q <= wdata_i[`RTC_WD_HI:`RTC_WD_LO];
        alarm_hour_tens_q <= wdata_i[`RTC_D2_HI:`RTC_D2_LO];
        alarm_hour_ones_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end
    if (wr_aminsec) begin
        alarm_minute_tens_q <= wdata_i[`RTC_MNT_HI:`RTC_MNT_LO];
        alarm_minute_ones_q <= wdata_i[`RTC_MNO_HI:`RTC_MNO_LO];
        alarm_second_tens_q <= wdata_i[`RTC_ST_HI:`RTC_ST_LO];
        alarm_second_ones_q <= wdata_i[`RTC_LO_HI:`RTC_LO_LO];
    end
end

// =====================================================
// read mux
// unused positions are zero from the default assignment or zero-filled by concatenation
always @* begin
    rdata_d = 16'h0000;
    case (addr_i)
        `RTC_OFS_CTRL: begin
            rdata_d[`RTC_UNLOCK_BIT] = time_write_unlock_q;
            rdata_d[`RTC_PTR_HI:`RTC_PTR_LO] = time_window_pointer_q;
        end
        `RTC_OFS_ACFG: begin
            rdata_d[`RTC_PTR_HI:`RTC_PTR_LO] = alarm_window_pointer_q;
        end
        `RTC_OFS_TWIN: begin
            case (time_window_pointer_q)
                `RTC_PTR_YEAR: begin
                    rdata_d = {8'h00, year_tens_digit_q, year_ones_digit_q};
                end
                `RTC_PTR_MODAY: begin
                    rdata_d = {3'h0, month_tens_digit_q, month_ones_digit_q,
                        2'h0, date_tens_digit_q, date_ones_digit_q};
                end
                `RTC_PTR_WDHR: begin
                    rdata_d = {5'h00, day_of_week_value_q,
                        2'h0, hour_tens_digit_q, hour_ones_digit_q};
                end
                default: begin
                    rdata_d = {1'b0, minute_tens_digit_q, minute_ones_digit_q,
                        1'b0, second_tens_digit_q, second_ones_digit_q};
                end
            endcase
        end
        `RTC_OFS_AWIN: begin
            case (alarm_window_pointer_q)
                `RTC_PTR_MODAY: begin
                    rdata_d = {3'h0, alarm_month_tens_q, alarm_month_ones_q,
                        2'h0, alarm_date_tens_q, alarm_date_ones_q};
                end
                `RTC_PTR_WDHR: begin
                    rdata_d = {5'h00, alarm_day_of_week_q,
                        2'h0, alarm_hour_tens_q, alarm_hour_ones_q};
                end
                `RTC_PTR_MINSEC: begin
                    rdata_d = {1'b0, alarm_minute_tens_q, alarm_minute_ones_q,
                        1'b0, alarm_second_tens_q, alarm_second_ones_q};
                end
                default: begin
                    rdata_d = 16'h0000;
                end
            endcase
        end
        default: begin
            rdata_d = 16'h0000;
        end
    endcase
end

// read data stands only in the cycle after the strobe
always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        rdata_o <= `RTC_RDATA_RST;
    end else if (rd_i) begin
        rdata_o <= rdata_d;
    end else begin
        rdata_o <= 16'h0000;
    end
end

endmodule
`default_nettype wire

// ### rtc_value_regs_assertions.sv
// port checker for the time and alarm value registers
// assumes it is bound to rtc_value_regs and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module rtc_value_regs_assertions (
    input wire mclk_i,
    input wire resetn_i,
    input wire [3:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire sec_tick_i,
    input wire [15:0] rdata_o
);
    reg [1:0] tptr_q;
    reg [1:0] aptr_q;
    wire t_rd = rd_i && addr_i == 4'h2;
    wire a_rd = rd_i && addr_i == 4'h3;
    // mirror of both pointers, so each layout check knows which word is shown
    always @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tptr_q <= 2'h0;
            aptr_q <= 2'h0;
        end else begin
            if (wr_i && addr_i == 4'h0)
                tptr_q <= wdata_i[9:8];
            else if ((wr_i || rd_i) && addr_i == 4'h2 && tptr_q != 2'h0)
                tptr_q <= tptr_q - 2'h1;
            if (wr_i && addr_i == 4'h1)
                aptr_q <= wdata_i[9:8];
            else if ((wr_i || rd_i) && addr_i == 4'h3 && aptr_q != 2'h0)
                aptr_q <= aptr_q - 2'h1;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    chk_idle_read_zero: assert property (
        !rd_i |=> rdata_o == 16'h0) else $error("read data not zero outside a read");
    chk_unmapped_read_zero: assert property (
        rdata_o != 16'h0 |-> $past(rd_i) && $past(addr_i) < 4'h4)
        else $error("data returned for an unmapped offset");
    chk_year_upper_zero: assert property (
        t_rd && tptr_q == 2'h3 |=> rdata_o[15:8] == 8'h0) else $error("year upper byte not zero");
    chk_moday_unused_zero: assert property (
        t_rd && tptr_q == 2'h2 ##1 1'b1 |-> (rdata_o & 16'hE0C0) == 16'h0)
        else $error("month/day unused bits set");
    chk_wdhr_unused_zero: assert property (
        t_rd && tptr_q == 2'h1 |=> (rdata_o & 16'hF8C0) == 16'h0)
        else $error("weekday/hours unused bits set");
    chk_minsec_unused_zero: assert property (
        t_rd && tptr_q == 2'h0 |=> (rdata_o & 16'h8080) == 16'h0)
        else $error("minutes/seconds unused bits set");
    chk_alarm_top_zero: assert property (
        a_rd && aptr_q == 2'h3 |=> rdata_o == 16'h0) else $error("alarm pointer 3 not zero");
    chk_alarm_moday_zero: assert property (
        a_rd && aptr_q == 2'h2 |=> (rdata_o & 16'hE0C0) == 16'h0)
        else $error("alarm month/day unused bits set");
    chk_alarm_wdhr_zero: assert property (
        a_rd && aptr_q == 2'h1 |=> (rdata_o & 16'hF8C0) == 16'h0)
        else $error("alarm weekday/hours unused bits set");
    chk_alarm_minsec_zero: assert property (
        a_rd && aptr_q == 2'h0 |=> (rdata_o & 16'h8080) == 16'h0)
        else $error("alarm minutes/seconds unused bits set");
    // the pointer fields read back must follow the mirrored walk
    chk_tptr_readback: assert property (
        rd_i && addr_i == 4'h0 |=> rdata_o[9:8] == $past(tptr_q))
        else $error("time pointer differs from its expected walk");
    chk_aptr_readback: assert property (
        rd_i && addr_i == 4'h1 |=> rdata_o[9:8] == $past(aptr_q))
        else $error("alarm pointer differs from its expected walk");
endmodule
bind rtc_value_regs rtc_value_regs_assertions i_rtc_value_regs_assertions (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .sec_tick_i(sec_tick_i), .rdata_o(rdata_o));
`default_nettype wire

// ### rtc_value_regs_test.sv
// self-checking bench for the time and alarm value registers
// assumes the register map of rtc_defs.vh and a read answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module rtc_value_regs_test;
    logic mclk_i;
    logic resetn_i;
    logic [3:0] addr_i;
    logic [15:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic sec_tick_i;
    wire [15:0] rdata_o;
    logic [15:0] exp_q[$];
    logic [15:0] msk_q[$];
    string nm_q[$];
    int fails;
    int checked;
    logic rd_seen;
    logic [15:0] rv;
    rtc_value_regs i_rtc_value_regs (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .sec_tick_i(sec_tick_i), .rdata_o(rdata_o));
    always #2 mclk_i = ~mclk_i;
    task give_verdict;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input logic w, input logic r, input logic t, input logic [3:0] a,
             input logic [15:0] d);
        @(posedge mclk_i);
        wr_i <= w;
        rd_i <= r;
        sec_tick_i <= t;
        addr_i <= a;
        wdata_i <= d;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        cyc(1'b1, 1'b0, 1'b0, a, d);
    endtask
    // masked-off bits are ones the bench cannot know, such as the unloaded month
    task rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m, input string n);
        exp_q.push_back(e);
        msk_q.push_back(m);
        nm_q.push_back(n);
        cyc(1'b0, 1'b1, 1'b0, a, 16'h0);
    endtask
    // ==========
    // monitor: the answer stands only in the cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            checked++;
            if (((rdata_o ^ exp_q[0]) & msk_q[0]) !== 16'h0) begin
                fails++;
                $display("MISMATCH %s expected=%h seen=%h", nm_q[0], exp_q[0], rdata_o);
            end
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
            void'(nm_q.pop_front());
        end
        rd_seen = rd_i;
    end
    initial begin
        #40000;
        fails++;
        $display("MISMATCH run_time expected=done seen=hang");
        give_verdict;
    end
    // ==========
    // main sequence
    initial begin
        mclk_i = 1'b0;
        resetn_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 16'h0;
        wr_i = 1'b0;
        rd_i = 1'b0;
        sec_tick_i = 1'b0;
        rd_seen = 1'b0;
        fails = 0;
        checked = 0;
        rv = $urandom(32'h4012);
        repeat (8) @(posedge mclk_i);
        checked++;
        if (rdata_o !== 16'h0) begin
            fails++;
            $display("MISMATCH reset_rdata expected=0000 seen=%h", rdata_o);
        end
        resetn_i <= 1'b1;
        wr(4'hA, 16'hFFFF);
        rd(4'hA, 16'h0, 16'hFFFF, "unmapped_a");
        rd(4'h7, 16'h0, 16'hFFFF, "unmapped_7");
        wr(4'h0, 16'h2300);
        wr(4'h2, 16'hFF24);
        wr(4'h2, 16'hFFD5);
        wr(4'h2, 16'hFDE2);
        wr(4'h2, 16'hD9D8);
        // all ones: only unlock and pointer may stick
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'h2300, 16'hFFFF, "ctrl_readback");
        rd(4'h2, 16'h0024, 16'hFFFF, "year");
        rd(4'h2, 16'h0015, 16'hE0FF, "month_day");
        rd(4'h2, 16'h0522, 16'hFFFF, "weekday_hours");
        rd(4'h2, 16'h5958, 16'hFFFF, "minsec");
        rd(4'h2, 16'h5958, 16'hFFFF, "minsec_hold");
        for (int i = 0; i < 2; i++) begin
            cyc(1'b0, 1'b0, 1'b1, 4'h0, 16'h0);
            wr(4'h0, 16'h2100);
            rd(4'h2, i ? 16'h0523 : 16'h0522, 16'hFFFF, "hours_tick");
            rd(4'h2, i ? 16'h0000 : 16'h5959, 16'hFFFF, "minsec_tick");
        end
        for (int i = 0; i < 4; i++) begin
            rv = {1'b0, 3'($urandom % 6), 4'($urandom % 10), 1'b0, 3'($urandom % 6),
                  4'($urandom % 10)};
            wr(4'h2, rv);
            rd(4'h2, rv, 16'hFFFF, "minsec_random");
        end
        // locked writes must leave every gated field as it was
        wr(4'h0, 16'h0300);
        wr(4'h2, 16'h0099);
        wr(4'h2, 16'h0001);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0300);
        rd(4'h2, 16'h0024, 16'hFFFF, "year_locked");
        rd(4'h2, 16'h0015, 16'hE0FF, "month_day_locked");
        rd(4'h2, 16'h0523, 16'hFFFF, "weekday_hours_locked");
        // midnight carry: hours and weekday wrap, day 01 steps whatever the month
        wr(4'h0, 16'h2200);
        wr(4'h2, 16'h0001);
        wr(4'h2, 16'h0623);
        wr(4'h2, 16'h5959);
        cyc(1'b0, 1'b0, 1'b1, 4'h0, 16'h0);
        wr(4'h0, 16'h2200);
        rd(4'h2, 16'h0002, 16'hE0FF, "day_carry");
        rd(4'h2, 16'h0000, 16'hFFFF, "weekday_wrap");
        rd(4'h2, 16'h0000, 16'hFFFF, "minsec_wrap");
        wr(4'h0, 16'h2000);
        wr(4'h1, 16'h0200);
        wr(4'h3, 16'hF2E5);
        wr(4'h3, 16'hFEE1);
        wr(4'h3, 16'hB7C5);
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0200);
        wr(4'h3, 16'h0000);
        wr(4'h3, 16'h0000);
        wr(4'h1, 16'hFFFF);
        rd(4'h1, 16'h0300, 16'hFFFF, "acfg_readback");
        rd(4'h3, 16'h0000, 16'hFFFF, "alarm_top");
        rd(4'h3, 16'h1225, 16'hFFFF, "alarm_month_day");
        rd(4'h3, 16'h0621, 16'hFFFF, "alarm_weekday_hours");
        rd(4'h3, 16'h3745, 16'hFFFF, "alarm_minsec");
        rd(4'h3, 16'h3745, 16'hFFFF, "alarm_minsec_hold");
        // second reset in mid-run: unlock and both pointers return to zero
        cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 16'h0000, 16'hFFFF, "ctrl_reset");
        rd(4'h1, 16'h0000, 16'hFFFF, "acfg_reset");
        cyc(1'b0, 1'b0, 1'b0, 4'h0, 16'h0);
        for (int i = 0; i < 20 && exp_q.size() > 0; i++)
            @(posedge mclk_i);
        if (exp_q.size() > 0) begin
            fails++;
            $display("MISMATCH read_answers expected=0 seen=%0d", exp_q.size());
        end
        give_verdict;
    end
endmodule
`default_nettype wire
